// ---- trace_pkg.sv ----
package trace_pkg;
	localparam int EVENT_COUNT = 16;
	localparam int EVENT_COUNT_W = 5;
	localparam int TRACE_DEPTH = 4194304;
	localparam int TRACE_ADDR_W = 22;
	localparam int DELAY_UNIT = 1048576;
	localparam logic [2:0] DELAY_SEL_MAX = 3'h4;
	localparam int SEG_PRE = 255;
	localparam int SEG_POST = 256;
	localparam int SEG_LEN = 512;
	localparam int SEQ_STEPS = 6;
	localparam int STATE_COUNT = 3;
	localparam int STATE_PATHS = 9;
	localparam int TIMEOUT_MIN_US = 10;
	localparam int CLK_MHZ = 10;
	localparam int TIMEOUT_MIN_CYC = TIMEOUT_MIN_US * CLK_MHZ;
	localparam logic OR_EN_RST = 1'b1;
	localparam logic OTHER_EN_RST = 1'b0;
	localparam logic [1:0] AUX_SEL_EXT = 2'h0;
	localparam logic [1:0] AUX_SEL_EVNUM = 2'h1;
	localparam logic [1:0] AUX_SEL_TASK = 2'h2;
	localparam logic [1:0] AUX_SEL_RST = AUX_SEL_EXT;

	typedef enum logic [2:0] {
		MODE_FILL_STOP = 3'h0,
		MODE_FILL_FULL = 3'h1,
		MODE_AROUND = 3'h2,
		MODE_REP_STOP = 3'h3,
		MODE_REP_FULL = 3'h4
	} trace_mode_t;

	typedef enum logic [2:0] {
		OTH_ACCUM = 3'h0,
		OTH_SIMUL = 3'h1,
		OTH_SUBR = 3'h2,
		OTH_SEQ = 3'h3,
		OTH_STATE = 3'h4
	} other_sel_t;
endpackage

// ---- trigger_combiner.sv ----
`timescale 1ns/100ps
`default_nettype none
module trigger_combiner
	import trace_pkg::*;
#(
	parameter int N = 16
) (
	input wire logic core_clk_in, // Clock
	input wire logic rst_in, // Async reset
	input wire logic restart_in, // Clear history
	input wire logic [N-1:0] event_in, // Event detector hits
	input wire logic [N-1:0] sel_in, // Configured events
	input wire other_sel_t kind_in, // Combiner choice
	input wire logic in_range_in, // Execution inside range
	input wire logic [3:0] subr_ev_in, // Subroutine event index
	input wire logic [23:0] seq_ev_in, // Six 4-bit step events
	input wire logic [2:0] seq_len_in, // Steps used, 1..6
	input wire logic [3:0] reset_ev_in, // Reset event index
	input wire logic [35:0] path_ev_in, // Nine 4-bit path events
	input wire logic [8:0] path_en_in, // Path enables
	input wire logic [1:0] final_state_in, // State that declares hit
	output logic hit_out // Combined condition
);
	logic [N-1:0] seen_q;
	logic [2:0] step_q;
	logic [1:0] st_q;
	logic [1:0] st_d;
	logic hit_c;
	logic rst_ev;
	logic [2:0] seq_top;

	assign rst_ev = event_in[reset_ev_in];
	assign seq_top = (seq_len_in == 3'h0) ? 3'h1 : seq_len_in;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_q <= '0;
		end else if (restart_in || hit_out) begin
			seen_q <= '0;
		end else begin
			seen_q <= seen_q | (event_in & sel_in);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_q <= 3'h0;
		end else if (restart_in || rst_ev || step_q >= seq_top) begin
			step_q <= 3'h0;
		end else if (event_in[seq_ev_in[step_q*4 +: 4]]) begin
			step_q <= step_q + 3'h1;
		end
	end

	// nine paths: path k goes from state k/3 to k%3
	always_comb begin
		st_d = st_q;
		for (int k = 0; k < STATE_PATHS; k++) begin
			if (path_en_in[k] && st_q == 2'(k / 3) && event_in[path_ev_in[k*4 +: 4]]) begin
				st_d = 2'(k % 3);
			end
		end
		if (rst_ev) begin
			st_d = 2'h0;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= 2'h0;
		end else if (restart_in) begin
			st_q <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		case (kind_in)
			OTH_ACCUM: hit_c = (sel_in != '0) && ((seen_q | event_in | ~sel_in) == '1);
			OTH_SIMUL: hit_c = (sel_in != '0) && ((event_in | ~sel_in) == '1);
			OTH_SUBR: hit_c = in_range_in && event_in[subr_ev_in];
			OTH_SEQ: hit_c = (step_q == seq_top - 3'h1) && !rst_ev
				&& event_in[seq_ev_in[step_q*4 +: 4]];
			OTH_STATE: hit_c = (st_d == final_state_in) && (st_q != final_state_in);
			default: hit_c = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hit_out <= 1'b0;
		end else begin
			hit_out <= hit_c && !restart_in;
		end
	end
endmodule // trigger_combiner
`default_nettype wire

// ---- bus_trace_capture_trigger.sv ----
// What this block does
// - Fill-until-stop wraps, stops only on halt
// - Fill-until-full stops when memory full
// - Around-trigger stops capture after delay or on halt
// - Delay choices 0,1M,2M,3M,4M cycles
// - Reject more than 16 enabled events
// - Repeat segment: none before, hit, 256 after
// - Repeat-until-stop runs until break or stop
// - Repeat-until-full ends on memory overflow
// - Consecutive hits: only first is marked
// - Step recording only in fill-until-stop
// - OR, other, exceptional sources combine freely
// - OR on any event, enabled after reset
// - One of five combiners, off after reset
// - Accumulated AND: every event seen once
// - Simultaneous AND: all events this cycle
// - Subroutine: event inside address range
// - Six ordered steps, reset event restarts
// - Three states, nine paths, reset event
// - Auxiliary field defaults to external trigger
// - Qualify in fill modes; triggers in others
`timescale 1ns/100ps
`default_nettype none
module bus_trace_capture_trigger
	import trace_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH,
	parameter int AW = TRACE_ADDR_W,
	parameter int DELAY_STEP = DELAY_UNIT,
	parameter int N = EVENT_COUNT
) (
	input wire logic core_clk_in, // Clock, 10 MHz
	input wire logic rst_in, // Async reset, high
	input wire logic bus_cycle_in, // One target bus cycle valid
	input wire logic prog_start_in, // Program execution starts
	input wire logic prog_halt_in, // Break or forced stop
	input wire logic step_active_in, // Cycle belongs to single step
	input wire logic cfg_load_in, // Load configuration below
	input wire trace_mode_t mode_in, // Acquisition mode
	input wire logic [2:0] delay_sel_in, // Post-trigger delay in 1M units
	input wire logic qualify_in, // Capture qualifier from filter
	input wire logic step_rec_in, // Record single-step cycles
	input wire logic or_en_in, // OR source enable
	input wire logic other_en_in, // Other-condition source enable
	input wire other_sel_t other_sel_in, // Combiner selection
	input wire logic exc_en_in, // Exceptional-event source enable
	input wire logic [1:0] aux_sel_in, // Auxiliary field source
	input wire logic [N-1:0] ev_sel_in, // Enabled events
	input wire logic [N-1:0] event_in, // Event detector hits
	input wire logic exc_event_in, // Exceptional event seen
	input wire logic in_range_in, // Execution inside range
	input wire logic [3:0] subr_ev_in, // Subroutine event index
	input wire logic [23:0] seq_ev_in, // Sequence step events
	input wire logic [2:0] seq_len_in, // Sequence length
	input wire logic [3:0] reset_ev_in, // Reset event index
	input wire logic [35:0] path_ev_in, // State path events
	input wire logic [8:0] path_en_in, // State path enables
	input wire logic [1:0] final_state_in, // Hit state
	input wire logic ext_trig_in, // External trigger level
	input wire logic [3:0] ev_num_in, // Event number
	input wire logic [3:0] task_id_in, // Task id
	output logic wr_en_out, // Write one trace entry
	output logic [AW-1:0] wr_addr_out, // Trace entry address
	output logic [3:0] wr_aux_out, // Auxiliary field of entry
	output logic wr_mark_out, // Entry is trigger point
	output logic acq_on_out, // Acquisition running
	output logic full_out, // Memory wrapped at least once
	output logic trig_out, // One-cycle trigger point pulse
	output logic cfg_err_out, // Last load rejected
	output trace_mode_t mode_out, // Active mode
	output logic [1:0] aux_sel_out // Active auxiliary source
);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [9:0] POST = 10'(SEG_POST);

	logic or_en_q, other_en_q, exc_en_q, step_rec_q;
	other_sel_t other_sel_q;
	logic [N-1:0] ev_sel_q;
	logic [2:0] delay_sel_q;
	logic [AW:0] delay_q;
	logic [AW:0] post_q;
	logic armed_q;
	logic [9:0] seg_q;
	logic prev_tp_q;
	logic [AW-1:0] seg_fill_q;
	logic other_hit;
	logic tp_raw, tp_new, rep_mode, fill_mode, take, full_hit;
	logic [EVENT_COUNT_W-1:0] n_sel;

	function automatic logic [EVENT_COUNT_W-1:0] popcount(input logic [N-1:0] v);
		logic [EVENT_COUNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < N; i++) begin
			c = c + EVENT_COUNT_W'(v[i]);
		end
		return c;
	endfunction

	assign n_sel = popcount(ev_sel_in);
	assign rep_mode = (mode_out == MODE_REP_STOP) || (mode_out == MODE_REP_FULL);
	assign fill_mode = (mode_out == MODE_FILL_STOP) || (mode_out == MODE_FILL_FULL)
		|| (mode_out == MODE_AROUND);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_out <= MODE_FILL_STOP;
			or_en_q <= OR_EN_RST;
			other_en_q <= OTHER_EN_RST;
			other_sel_q <= OTH_ACCUM;
			exc_en_q <= 1'b0;
			step_rec_q <= 1'b0;
			aux_sel_out <= AUX_SEL_RST;
			ev_sel_q <= '0;
			delay_sel_q <= 3'h0;
			cfg_err_out <= 1'b0;
		end else if (cfg_load_in && !acq_on_out) begin
			if (n_sel > EVENT_COUNT_W'(EVENT_COUNT) || delay_sel_in > DELAY_SEL_MAX
				|| mode_in > MODE_REP_FULL || other_sel_in > OTH_STATE) begin
				cfg_err_out <= 1'b1;
			end else begin
				cfg_err_out <= 1'b0;
				mode_out <= mode_in;
				or_en_q <= or_en_in;
				other_en_q <= other_en_in;
				other_sel_q <= other_sel_in;
				exc_en_q <= exc_en_in;
				step_rec_q <= step_rec_in && (mode_in == MODE_FILL_STOP);
				aux_sel_out <= aux_sel_in;
				ev_sel_q <= ev_sel_in;
				delay_sel_q <= delay_sel_in;
			end
		end
	end

	trigger_combiner #(.N(N)) u_comb (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.restart_in(prog_start_in),
		.event_in(event_in),
		.sel_in(ev_sel_q),
		.kind_in(other_sel_q),
		.in_range_in(in_range_in),
		.subr_ev_in(subr_ev_in),
		.seq_ev_in(seq_ev_in),
		.seq_len_in(seq_len_in),
		.reset_ev_in(reset_ev_in),
		.path_ev_in(path_ev_in),
		.path_en_in(path_en_in),
		.final_state_in(final_state_in),
		.hit_out(other_hit)
	);

	assign tp_raw = acq_on_out && !fill_mode_no_tp()
		&& ((or_en_q && |(event_in & ev_sel_q)) || (other_en_q && other_hit)
		|| (exc_en_q && exc_event_in));
	assign tp_new = tp_raw && !prev_tp_q;

	function automatic logic fill_mode_no_tp();
		return (mode_out == MODE_FILL_STOP) || (mode_out == MODE_FILL_FULL);
	endfunction

	// last address just written in a full mode
	// Blocks this cycle's capture so the first entry is never overwritten
	assign full_hit = (mode_out == MODE_FILL_FULL || mode_out == MODE_REP_FULL)
		&& wr_en_out && wr_addr_out == LAST;

	// qualify only fill modes; step cycles gated
	assign take = bus_cycle_in && acq_on_out && !full_hit
		&& (rep_mode ? (seg_q != 10'h0 || tp_new) : qualify_in)
		&& (!step_active_in || step_rec_q);

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_tp_q <= 1'b0;
			trig_out <= 1'b0;
		end else begin
			prev_tp_q <= tp_raw;
			trig_out <= tp_new;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seg_q <= 10'h0;
		end else if (prog_start_in) begin
			seg_q <= 10'h0;
		end else if (rep_mode && tp_new && seg_q == 10'h0) begin
			seg_q <= POST;
		end else if (seg_q != 10'h0 && bus_cycle_in) begin
			seg_q <= seg_q - 10'h1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			delay_q <= '0;
		end else begin
			delay_q <= (AW+1)'(delay_sel_q * DELAY_STEP);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			acq_on_out <= 1'b0;
			armed_q <= 1'b0;
			post_q <= '0;
		end else if (prog_start_in) begin
			acq_on_out <= 1'b1;
			armed_q <= 1'b0;
			post_q <= '0;
		end else if (prog_halt_in) begin
			acq_on_out <= 1'b0;
		end else if (acq_on_out) begin
			if (full_hit) begin
				acq_on_out <= 1'b0;
			end
			if (mode_out == MODE_AROUND) begin
				if (!armed_q && tp_new) begin
					armed_q <= 1'b1;
					post_q <= '0;
					if (delay_q == '0) begin
						acq_on_out <= 1'b0;
					end
				end else if (armed_q && take) begin
					post_q <= post_q + (AW+1)'(1);
					if (post_q + (AW+1)'(1) >= delay_q) begin
						acq_on_out <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_en_out <= 1'b0;
			wr_addr_out <= '0;
			wr_mark_out <= 1'b0;
			wr_aux_out <= 4'h0;
			full_out <= 1'b0;
			seg_fill_q <= '0;
		end else if (prog_start_in) begin
			wr_en_out <= 1'b0;
			wr_addr_out <= '0;
			full_out <= 1'b0;
			seg_fill_q <= '0;
		end else begin
			wr_en_out <= take;
			wr_mark_out <= take && tp_new;
			if (wr_en_out) begin
				wr_addr_out <= (wr_addr_out == LAST) ? '0 : wr_addr_out + AW'(1);
				if (wr_addr_out == LAST) begin
					full_out <= 1'b1;
				end
			end
			case (aux_sel_out)
				AUX_SEL_EVNUM: wr_aux_out <= ev_num_in;
				AUX_SEL_TASK: wr_aux_out <= task_id_in;
				default: wr_aux_out <= {3'h0, ext_trig_in};
			endcase
		end
	end

	// No pre-trigger part is written: a segment starts at the hit entry
	// segment length check
	repeat_post_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(rep_mode && tp_new && seg_q == 10'h0 && !prog_start_in) |=> seg_q == POST)
	else $error("segment post count not loaded");

	single_mark_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		trig_out |=> !trig_out)
	else $error("two trigger marks back to back");

	full_stop_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(mode_out == MODE_FILL_FULL && wr_en_out && wr_addr_out == LAST
		&& !prog_start_in) |=> !acq_on_out && !wr_en_out)
	else $error("fill-until-full kept capturing");

	halt_stop_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(prog_halt_in && !prog_start_in) |=> !acq_on_out ##1 !wr_en_out)
	else $error("capture continued after halt");

	ptr_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		prog_start_in |=> wr_addr_out == '0 && !full_out)
	else $error("pointer not cleared on start");

	cfg_reject_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(cfg_load_in && !acq_on_out && n_sel > EVENT_COUNT_W'(EVENT_COUNT)) |=> cfg_err_out)
	else $error("oversize event set accepted");

	fill_notrig_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		fill_mode_no_tp() |-> !tp_raw)
	else $error("trigger raised in plain fill mode");

	step_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		(mode_out != MODE_FILL_STOP) |-> !step_rec_q)
	else $error("step recording outside fill-until-stop");
endmodule // bus_trace_capture_trigger
`default_nettype wire

// ---- target_bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far side of the trace block: the target bus, one cycle per clock while running
module target_bus_model (
	input wire logic core_clk_in, // Clock
	input wire logic run_in, // Target executing
	input wire logic [15:0] ev_req_in, // Events wanted next cycle
	input wire logic step_in, // Host is single-stepping
	output logic bus_cycle_out, // Bus cycle valid
	output logic [15:0] event_out, // Event detector hits
	output logic exc_event_out, // Exceptional event
	output logic in_range_out, // Inside address range
	output logic step_active_out // Single-step cycle
);
	// Events only ride on a real bus cycle; a stopped target raises none
	always_ff @(posedge core_clk_in) begin
		bus_cycle_out <= run_in;
		event_out <= run_in ? ev_req_in : 16'h0000;
	end
	// Side lines wander every cycle (step only while running and stepping), so a stale level never passes for a held one
	always_ff @(posedge core_clk_in) begin
		exc_event_out <= 1'($urandom);
		in_range_out <= 1'($urandom);
		step_active_out <= run_in & step_in & 1'($urandom);
	end
endmodule // target_bus_model
`default_nettype wire

// ---- bus_trace_capture_trigger_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module bus_trace_capture_trigger_tb_top;
	import trace_pkg::*;
	localparam int D = 64;
	localparam int STEP = 8;
	logic core_clk_in, rst_in, prog_start_in, prog_halt_in, cfg_load_in, qualify_in;
	logic step_rec_in, or_en_in, other_en_in, exc_en_in, ext_trig_in, run;
	logic bus_cycle, exc_event, in_range, step_active, step_en;
	trace_mode_t mode_in, mode_out;
	other_sel_t other_sel_in;
	logic [2:0] delay_sel_in, seq_len_in;
	logic [1:0] aux_sel_in, final_state_in, aux_sel_out;
	logic [15:0] ev_sel_in, ev_req, events;
	logic [3:0] subr_ev_in, reset_ev_in, ev_num_in, task_id_in, wr_aux_out;
	logic [23:0] seq_ev_in;
	logic [35:0] path_ev_in;
	logic [8:0] path_en_in;
	logic wr_en_out, wr_mark_out, acq_on_out, full_out, trig_out, cfg_err_out;
	logic [5:0] wr_addr_out, exp_addr;
	int bad_count, n_tests, stores, marks, mark_at, trigs, cyc, m1;

	target_bus_model bus (.core_clk_in(core_clk_in), .run_in(run), .ev_req_in(ev_req),
		.step_in(step_en),
		.bus_cycle_out(bus_cycle), .event_out(events), .exc_event_out(exc_event),
		.in_range_out(in_range), .step_active_out(step_active));

	bus_trace_capture_trigger #(.DEPTH(D), .AW(6), .DELAY_STEP(STEP), .N(16)) dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .bus_cycle_in(bus_cycle),
		.prog_start_in(prog_start_in), .prog_halt_in(prog_halt_in),
		.step_active_in(step_active), .cfg_load_in(cfg_load_in), .mode_in(mode_in),
		.delay_sel_in(delay_sel_in), .qualify_in(qualify_in), .step_rec_in(step_rec_in),
		.or_en_in(or_en_in), .other_en_in(other_en_in), .other_sel_in(other_sel_in),
		.exc_en_in(exc_en_in), .aux_sel_in(aux_sel_in), .ev_sel_in(ev_sel_in),
		.event_in(events), .exc_event_in(exc_event), .in_range_in(in_range),
		.subr_ev_in(subr_ev_in), .seq_ev_in(seq_ev_in), .seq_len_in(seq_len_in),
		.reset_ev_in(reset_ev_in), .path_ev_in(path_ev_in), .path_en_in(path_en_in),
		.final_state_in(final_state_in), .ext_trig_in(ext_trig_in), .ev_num_in(ev_num_in),
		.task_id_in(task_id_in), .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out),
		.wr_aux_out(wr_aux_out), .wr_mark_out(wr_mark_out), .acq_on_out(acq_on_out),
		.full_out(full_out), .trig_out(trig_out), .cfg_err_out(cfg_err_out),
		.mode_out(mode_out), .aux_sel_out(aux_sel_out));

	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask

	task automatic load(input trace_mode_t m, input logic [2:0] d);
		mode_in = m;
		delay_sel_in = d;
		cfg_load_in = 1'b1;
		tick(1);
		cfg_load_in = 1'b0;
		tick(1);
	endtask

	task automatic start();
		prog_start_in = 1'b1;
		{stores, marks, trigs, mark_at} = '0;
		exp_addr = 6'h00;
		tick(1);
		prog_start_in = 1'b0;
		run = 1'b1;
	endtask

	task automatic halt();
		run = 1'b0;
		prog_halt_in = 1'b1;
		tick(1);
		prog_halt_in = 1'b0;
		tick(3);
	endtask

	task automatic hit(input logic [15:0] e, input int n);
		ev_req = e;
		tick(n);
		ev_req = 16'h0000;
	endtask

	task automatic print_verdict();
		$display("TB: tests=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Every stored entry must land on the next address, wrapping at the end
	always @(posedge core_clk_in) begin
		if (wr_en_out === 1'b1) begin
			chk(wr_addr_out, exp_addr);
			exp_addr = exp_addr + 6'h01;
			if (wr_mark_out === 1'b1) begin
				marks++;
				mark_at = stores;
			end
			stores++;
		end
		if (trig_out === 1'b1)
			trigs++;
	end

	// Whole run needs under two thousand cycles
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		{rst_in, or_en_in} = 2'h3;
		{prog_start_in, prog_halt_in, cfg_load_in, qualify_in, step_rec_in} = '0;
		{other_en_in, exc_en_in, ext_trig_in, run, step_en} = '0;
		{bad_count, n_tests, stores, marks, mark_at, trigs, cyc, m1} = '0;
		mode_in = MODE_FILL_STOP;
		other_sel_in = OTH_ACCUM;
		{delay_sel_in, ev_req, ev_num_in, task_id_in} = '0;
		ev_sel_in = 16'h0008;
		exp_addr = 6'h00;
		void'($urandom(14));
		{seq_ev_in, path_ev_in} = 60'({$urandom, $urandom});
		{path_en_in, reset_ev_in, subr_ev_in} = 17'($urandom);
		seq_len_in = 3'(1 + $urandom % 6);
		final_state_in = 2'($urandom % 3);
		aux_sel_in = 2'($urandom % 3);
		tick(12);
		rst_in = 1'b0;
		tick(1);
		$display("TB: test reset");
		chk(aux_sel_out, AUX_SEL_EXT);
		chk(acq_on_out, 1'b0);
		$display("TB: test fill until stop");
		step_rec_in = 1'b1;
		step_en = 1'b1;
		load(MODE_FILL_STOP, 3'h0);
		chk(aux_sel_out, aux_sel_in);
		start();
		for (int i = 0; i < 90; i++) begin
			qualify_in = (i < 70) | 1'($urandom);
			{ext_trig_in, ev_num_in, task_id_in} = 9'($urandom);
			ev_req = 16'($urandom);
			tick(1);
		end
		ev_req = 16'h0000;
		chk(full_out, 1'b1);
		chk(acq_on_out, 1'b1);
		chk(trigs, 0);
		halt();
		step_en = 1'b0;
		chk(acq_on_out, 1'b0);
		$display("TB: test fill until full");
		qualify_in = 1'b1;
		load(MODE_FILL_FULL, 3'h0);
		start();
		tick(D + 20);
		chk(stores, D);
		chk(acq_on_out, 1'b0);
		halt();
		load(MODE_AROUND, 3'h5);
		chk(cfg_err_out, 1'b1);
		chk(mode_out, MODE_FILL_FULL);
		$display("TB: test stop after trigger delay");
		for (int d = 0; d < 3; d++) begin
			load(MODE_AROUND, 3'(d));
			start();
			tick(10);
			hit(16'h0008, 1);
			tick(d * STEP + 20);
			chk(acq_on_out, 1'b0);
			chk(stores - mark_at - 1, d * STEP);
			chk(trigs, 1);
			halt();
		end
		$display("TB: test repeat until full");
		load(MODE_REP_FULL, 3'h0);
		start();
		tick(10);
		hit(16'h0008, 3);
		tick(D + 20);
		chk(trigs, 1);
		chk(marks, 1);
		chk(stores, D);
		chk(acq_on_out, 1'b0);
		halt();
		$display("TB: test repeat until stop");
		qualify_in = 1'b0;
		load(MODE_REP_STOP, 3'h0);
		start();
		tick(10);
		hit(16'h0008, 1);
		tick(300);
		m1 = mark_at;
		load(MODE_FILL_FULL, 3'h0);
		chk(mode_out, MODE_REP_STOP);
		hit(16'h0008, 1);
		tick(300);
		chk(mark_at - m1, SEG_POST + 1);
		chk(marks, 2);
		chk(acq_on_out, 1'b1);
		halt();
		chk(acq_on_out, 1'b0);
		$display("TB: test combiners");
		// no state timeout is set, so no round-trip spacing is owed
		{or_en_in, other_en_in} = 2'h1;
		ev_sel_in = 16'h0003;
		for (int k = 0; k < 2; k++) begin
			other_sel_in = k ? OTH_SIMUL : OTH_ACCUM;
			load(MODE_AROUND, 3'h0);
			start();
			tick(5);
			hit(16'h0001, 1);
			tick(3);
			hit(16'h0002, 1);
			tick(5);
			chk(trigs, k ? 0 : 1);
			hit(16'h0003, 1);
			tick(5);
			chk(trigs, 1);
			halt();
		end
		print_verdict();
	end
endmodule // bus_trace_capture_trigger_tb_top
`default_nettype wire
